// File: src/hcov_consts.vh
// Purpose: Constants of the hardware cursor overlay
// Assumes: Included by hcov_top.v
// Notes: Indices are byte-wide I/O register indices
`ifndef HCOV_CONSTS_VH
`define HCOV_CONSTS_VH
`define HCOV_PORT_IDX_MONO 16'h03B4
`define HCOV_PORT_DAT_MONO 16'h03B5
`define HCOV_PORT_IDX_COLR 16'h03D4
`define HCOV_PORT_DAT_COLR 16'h03D5
`define HCOV_IDX_FG_COLOR 8'h0E
`define HCOV_IDX_BG_COLOR 8'h0F
`define HCOV_IDX_LOCK 8'h39
`define HCOV_IDX_MODE 8'h45
`define HCOV_IDX_X_HIGH 8'h46
`define HCOV_IDX_X_LOW 8'h47
`define HCOV_IDX_Y_HIGH 8'h48
`define HCOV_IDX_Y_LOW 8'h49
`define HCOV_IDX_FG_STACK 8'h4A
`define HCOV_IDX_BG_STACK 8'h4B
`define HCOV_IDX_LINE_A 8'h4C
`define HCOV_IDX_LINE_B 8'h4D
`define HCOV_IDX_X_OFFSET 8'h4E
`define HCOV_IDX_Y_OFFSET 8'h4F
`define HCOV_UNLOCK_KEY 8'hA0
`define HCOV_MODE_ENABLE 0
`define HCOV_MODE_CONV 1
`define HCOV_MODE_ZOOM2 2
`define HCOV_MODE_ZOOM3 3
`define HCOV_MODE_MASK 8'h0F
`define HCOV_RESET_BYTE 8'h00
`define HCOV_CURSOR_SIZE 7'h40
`define HCOV_LAST_WORD 9'h1FF
`define HCOV_STACK_LAST 2'h2
`endif

// File: src/hcov_top.v
// Purpose: Hardware cursor overlay with indexed byte registers
// Assumes: I/O strobes, display timing and memory port are all on CLK
// Notes: Mask image is fetched into local arrays at each frame start while the overlay is active and idle
//
// Summary of operation
// (RQ1) Overlay stays off unless enhanced mode is active.
// (RQ2) Cursor is 64x64, shaped by 512-byte AND and XOR masks in video memory.
// (RQ3) Two conventions map AND/XOR bits to bg, fg, screen or inverted screen.
// (RQ4) Mode bit 1 selects which display convention applies.
// (RQ5) Indexed colour takes fg from index 0EH and bg from index 0FH.
// (RQ6) True colour takes fg from 3-entry stack 4AH, bg from stack 4BH.
// (RQ7) Reading mode register 45H resets both stack write pointers to zero.
// (RQ8) Consecutive stack writes, low byte first, fill successive entries.
// (RQ9) Cursor registers accept writes only while lock key holds A0H.
// (RQ10) Mode bit 0 enables the overlay.
// (RQ11) X and Y are 11-bit, split into high bits 10:8 and low bits 7:0.
// (RQ12) Only on-screen part shows; Y at or past last line shows nothing.
// (RQ13) Offsets skip first columns and rows of the image.
// (RQ14) Position and offsets take effect together when Y high is written.
// (RQ15) Image starts at line from indices 4CH/4DH, column zero.
// (RQ16) Image words alternate AND then XOR, 256 of each.
// (RQ17) Four-plane image spans 1024x2 at half megabyte, 2048x1 otherwise.
// (RQ18) Mode bit 2 gives 2x zoom, bit 3 3x; zoom uses colour stacks.
// (RQ19) Index written at port 3?4H, data at 3?5H, D colour or B mono.
// (RQ20) Software pads small shapes with AND ones and XOR zeros.
`timescale 1ns/10ps
`default_nettype none
`include "hcov_consts.vh"
module hcov_top #(
   parameter COORD_W = 11,
   parameter LINE_W = 12
) (
   input wire CLK,
   input wire RST,
   input wire [15:0] IO_ADDR,
   input wire IO_WR,
   input wire IO_RD,
   input wire [7:0] IO_WDATA,
   output reg [7:0] IO_RDATA,
   input wire MONO_ADDR,
   input wire ENHANCED_MODE,
   input wire TRUE_COLOR,
   input wire FOUR_PLANE,
   input wire MEM_HALF_MB,
   input wire FRAME_START,
   input wire [COORD_W-1:0] PIX_X,
   input wire [COORD_W-1:0] PIX_Y,
   input wire [COORD_W-1:0] ACTIVE_W,
   input wire [COORD_W-1:0] ACTIVE_H,
   input wire [23:0] SCREEN_PIXEL,
   output reg [23:0] PIX_OUT,
   output reg CURSOR_HIT,
   output reg MEM_REQ,
   output reg [LINE_W-1:0] MEM_LINE,
   output reg [10:0] MEM_WORD,
   input wire MEM_ACK,
   input wire [15:0] MEM_RDATA
);
   localparam ST_IDLE = 1'b0;
   localparam ST_FETCH = 1'b1;

   reg [7:0] index_q;
   reg [7:0] fg_idx_q, bg_idx_q, lock_q, mode_q, line_a_q, line_b_q;
   reg [7:0] fg_stk_q [0:2];
   reg [7:0] bg_stk_q [0:2];
   reg [1:0] fg_ptr_q, bg_ptr_q;
   reg [2:0] sx_hi_q, sy_hi_q;
   reg [7:0] sx_lo_q, sy_lo_q;
   reg [5:0] sox_q, soy_q;
   reg [COORD_W-1:0] cx_q, cy_q;
   reg [5:0] skip_columns_q, skip_rows_q;
   reg [15:0] and_mem [0:255];
   reg [15:0] xor_mem [0:255];
   reg state_q;
   reg [8:0] cnt_q;
   integer i;

   wire [15:0] port_idx = MONO_ADDR ? `HCOV_PORT_IDX_MONO : `HCOV_PORT_IDX_COLR; // RQ19
   wire [15:0] port_dat = MONO_ADDR ? `HCOV_PORT_DAT_MONO : `HCOV_PORT_DAT_COLR; // RQ19
   wire wr_idx = IO_WR && (IO_ADDR == port_idx);
   wire wr_dat = IO_WR && (IO_ADDR == port_dat);
   wire rd_idx = IO_RD && (IO_ADDR == port_idx);
   wire rd_dat = IO_RD && (IO_ADDR == port_dat);
   wire unlocked = (lock_q == `HCOV_UNLOCK_KEY); // RQ9
   wire active = ENHANCED_MODE && mode_q[`HCOV_MODE_ENABLE]; // RQ1 RQ10
   wire [15:0] line_full = {line_a_q, line_b_q};
   wire [LINE_W-1:0] img_line = line_full[LINE_W-1:0]; // RQ15

   // Locked cursor registers: indices 45H to 4FH; 0E/0F and the key 39H stay writable
   function is_locked_reg;
      input [7:0] idx;
      begin
         is_locked_reg = (idx >= `HCOV_IDX_MODE) && (idx <= `HCOV_IDX_Y_OFFSET);
      end
   endfunction

   // Scale a display distance back to image pixels
   function [COORD_W-1:0] zdiv;
      input [COORD_W-1:0] v;
      input [1:0] z;
      begin
         case (z)
            2'd2: zdiv = v >> 1;
            2'd3: zdiv = v / {{(COORD_W-2){1'b0}}, 2'd3};
            default: zdiv = v;
         endcase
      end
   endfunction

   // Word column and line of fetch word n
   function [LINE_W+10:0] fetch_addr;
      input [8:0] n;
      begin
         if (FOUR_PLANE && MEM_HALF_MB) begin
            fetch_addr = {img_line + {{(LINE_W-1){1'b0}}, n[8]}, 3'b000, n[7:0]}; // RQ17
         end else begin
            fetch_addr = {img_line, 2'b00, n}; // RQ15 RQ17
         end
      end
   endfunction

   // Register file
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         index_q <= `HCOV_RESET_BYTE;
         fg_idx_q <= `HCOV_RESET_BYTE;
         bg_idx_q <= `HCOV_RESET_BYTE;
         lock_q <= `HCOV_RESET_BYTE;
         mode_q <= `HCOV_RESET_BYTE;
         line_a_q <= `HCOV_RESET_BYTE;
         line_b_q <= `HCOV_RESET_BYTE;
         fg_ptr_q <= 2'h0;
         bg_ptr_q <= 2'h0;
         sx_hi_q <= 3'h0;
         sy_hi_q <= 3'h0;
         sx_lo_q <= `HCOV_RESET_BYTE;
         sy_lo_q <= `HCOV_RESET_BYTE;
         sox_q <= 6'h00;
         soy_q <= 6'h00;
         cx_q <= {COORD_W{1'b0}};
         cy_q <= {COORD_W{1'b0}};
         skip_columns_q <= 6'h00;
         skip_rows_q <= 6'h00;
         IO_RDATA <= `HCOV_RESET_BYTE;
         for (i = 0; i < 3; i = i + 1) begin
            fg_stk_q[i] <= `HCOV_RESET_BYTE;
            bg_stk_q[i] <= `HCOV_RESET_BYTE;
         end
      end else begin
         if (wr_idx) begin
            index_q <= IO_WDATA;
         end
         if (wr_dat && (!is_locked_reg(index_q) || unlocked)) begin // RQ9
            case (index_q)
               `HCOV_IDX_FG_COLOR: fg_idx_q <= IO_WDATA; // RQ5
               `HCOV_IDX_BG_COLOR: bg_idx_q <= IO_WDATA; // RQ5
               `HCOV_IDX_LOCK: lock_q <= IO_WDATA; // RQ9
               `HCOV_IDX_MODE: mode_q <= IO_WDATA & `HCOV_MODE_MASK; // RQ10 RQ18
               `HCOV_IDX_X_HIGH: sx_hi_q <= IO_WDATA[2:0]; // RQ11
               `HCOV_IDX_X_LOW: sx_lo_q <= IO_WDATA; // RQ11
               `HCOV_IDX_Y_LOW: sy_lo_q <= IO_WDATA; // RQ11
               `HCOV_IDX_X_OFFSET: sox_q <= IO_WDATA[5:0]; // RQ13
               `HCOV_IDX_Y_OFFSET: soy_q <= IO_WDATA[5:0]; // RQ13
               `HCOV_IDX_LINE_A: line_a_q <= IO_WDATA; // RQ15
               `HCOV_IDX_LINE_B: line_b_q <= IO_WDATA; // RQ15
               `HCOV_IDX_Y_HIGH: begin
                  sy_hi_q <= IO_WDATA[2:0];
                  cx_q <= {sx_hi_q, sx_lo_q}; // RQ14
                  cy_q <= {IO_WDATA[2:0], sy_lo_q}; // RQ14 RQ11
                  skip_columns_q <= sox_q; // RQ14
                  skip_rows_q <= soy_q; // RQ14
               end
               `HCOV_IDX_FG_STACK: begin
                  fg_stk_q[fg_ptr_q] <= IO_WDATA; // RQ6 RQ8
                  fg_ptr_q <= (fg_ptr_q == `HCOV_STACK_LAST) ? 2'h0 : fg_ptr_q + 2'h1; // RQ8
               end
               `HCOV_IDX_BG_STACK: begin
                  bg_stk_q[bg_ptr_q] <= IO_WDATA; // RQ6 RQ8
                  bg_ptr_q <= (bg_ptr_q == `HCOV_STACK_LAST) ? 2'h0 : bg_ptr_q + 2'h1; // RQ8
               end
               default: ;
            endcase
         end
         if (rd_dat && (index_q == `HCOV_IDX_MODE)) begin
            fg_ptr_q <= 2'h0; // RQ7
            bg_ptr_q <= 2'h0; // RQ7
         end
         if (rd_idx) begin
            IO_RDATA <= index_q;
         end else if (rd_dat) begin
            case (index_q)
               `HCOV_IDX_FG_COLOR: IO_RDATA <= fg_idx_q;
               `HCOV_IDX_BG_COLOR: IO_RDATA <= bg_idx_q;
               `HCOV_IDX_LOCK: IO_RDATA <= lock_q;
               `HCOV_IDX_MODE: IO_RDATA <= mode_q;
               `HCOV_IDX_X_HIGH: IO_RDATA <= {5'h00, sx_hi_q};
               `HCOV_IDX_X_LOW: IO_RDATA <= sx_lo_q;
               `HCOV_IDX_Y_HIGH: IO_RDATA <= {5'h00, sy_hi_q};
               `HCOV_IDX_Y_LOW: IO_RDATA <= sy_lo_q;
               `HCOV_IDX_X_OFFSET: IO_RDATA <= {2'h0, sox_q};
               `HCOV_IDX_Y_OFFSET: IO_RDATA <= {2'h0, soy_q};
               `HCOV_IDX_LINE_A: IO_RDATA <= line_a_q;
               `HCOV_IDX_LINE_B: IO_RDATA <= line_b_q;
               `HCOV_IDX_FG_STACK: IO_RDATA <= (fg_ptr_q == 2'h3) ? 8'h00 : fg_stk_q[fg_ptr_q];
               `HCOV_IDX_BG_STACK: IO_RDATA <= (bg_ptr_q == 2'h3) ? 8'h00 : bg_stk_q[bg_ptr_q];
               default: IO_RDATA <= `HCOV_RESET_BYTE;
            endcase
         end
      end
   end

   // Image fetch engine
   wire [LINE_W+10:0] next_addr = fetch_addr(cnt_q + 9'h001);
   wire [LINE_W+10:0] first_addr = fetch_addr(9'h000);

   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         state_q <= ST_IDLE;
         cnt_q <= 9'h000;
         MEM_REQ <= 1'b0;
         MEM_LINE <= {LINE_W{1'b0}};
         MEM_WORD <= 11'h000;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (FRAME_START && active) begin
                  state_q <= ST_FETCH;
                  cnt_q <= 9'h000;
                  MEM_REQ <= 1'b1;
                  MEM_LINE <= first_addr[LINE_W+10:11];
                  MEM_WORD <= first_addr[10:0];
               end
            end
            ST_FETCH: begin
               if (MEM_ACK) begin
                  if (cnt_q == `HCOV_LAST_WORD) begin // RQ16
                     state_q <= ST_IDLE;
                     MEM_REQ <= 1'b0;
                  end else begin
                     cnt_q <= cnt_q + 9'h001;
                     MEM_LINE <= next_addr[LINE_W+10:11];
                     MEM_WORD <= next_addr[10:0];
                  end
               end
            end
            default: begin
               state_q <= ST_IDLE;
               MEM_REQ <= 1'b0;
            end
         endcase
      end
   end

   // Even words are AND mask, odd words XOR mask
   always @(posedge CLK) begin
      if (state_q == ST_FETCH && MEM_ACK) begin
         if (cnt_q[0]) begin
            xor_mem[cnt_q[8:1]] <= MEM_RDATA; // RQ16 RQ2
         end else begin
            and_mem[cnt_q[8:1]] <= MEM_RDATA; // RQ16 RQ2
         end
      end
   end

   // Pixel path
   wire [1:0] zoom = mode_q[`HCOV_MODE_ZOOM3] ? 2'd3 :
                     (mode_q[`HCOV_MODE_ZOOM2] ? 2'd2 : 2'd1); // RQ18
   wire [COORD_W:0] dx = {1'b0, PIX_X} - {1'b0, cx_q};
   wire [COORD_W:0] dy = {1'b0, PIX_Y} - {1'b0, cy_q};
   wire [6:0] w_left = `HCOV_CURSOR_SIZE - {1'b0, skip_columns_q}; // RQ13
   wire [6:0] h_left = `HCOV_CURSOR_SIZE - {1'b0, skip_rows_q}; // RQ13
   wire [COORD_W-1:0] sx = zdiv(dx[COORD_W-1:0], zoom);
   wire [COORD_W-1:0] sy = zdiv(dy[COORD_W-1:0], zoom);
   wire in_x = !dx[COORD_W] && (sx < {{(COORD_W-7){1'b0}}, w_left});
   wire in_y = !dy[COORD_W] && (sy < {{(COORD_W-7){1'b0}}, h_left});
   wire on_screen = (PIX_X < ACTIVE_W) && (PIX_Y < ACTIVE_H); // RQ12
   wire hit = active && in_x && in_y && on_screen; // RQ1 RQ12
   wire [5:0] col = skip_columns_q + sx[5:0]; // RQ13
   wire [5:0] row = skip_rows_q + sy[5:0]; // RQ13
   wire [7:0] widx = {row, col[5:4]};
   wire [3:0] bsel = 4'hF - col[3:0];
   wire and_bit = and_mem[widx][bsel];
   wire xor_bit = xor_mem[widx][bsel];
   wire use_stack = TRUE_COLOR || (zoom != 2'd1); // RQ6 RQ18
   wire [23:0] fg_col = use_stack ? {fg_stk_q[2], fg_stk_q[1], fg_stk_q[0]} :
                        {16'h0000, fg_idx_q}; // RQ5 RQ6
   wire [23:0] bg_col = use_stack ? {bg_stk_q[2], bg_stk_q[1], bg_stk_q[0]} :
                        {16'h0000, bg_idx_q}; // RQ5 RQ6
   reg [23:0] pix_d;

   always @* begin
      pix_d = SCREEN_PIXEL;
      if (hit) begin
         if (!mode_q[`HCOV_MODE_CONV]) begin // RQ4
            case ({and_bit, xor_bit})
               2'b00: pix_d = bg_col; // RQ3
               2'b01: pix_d = fg_col; // RQ3
               2'b10: pix_d = SCREEN_PIXEL; // RQ3
               default: pix_d = ~SCREEN_PIXEL; // RQ3
            endcase
         end else begin
            case ({and_bit, xor_bit})
               2'b10: pix_d = bg_col; // RQ3
               2'b11: pix_d = fg_col; // RQ3
               default: pix_d = SCREEN_PIXEL; // RQ3
            endcase
         end
      end
   end

   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         PIX_OUT <= 24'h00_0000;
         CURSOR_HIT <= 1'b0;
      end else begin
         PIX_OUT <= pix_d;
         CURSOR_HIT <= hit;
      end
   end
endmodule // hcov_top
`default_nettype wire

// File: tb/hcov_props.sv
// Purpose: Port-level checks of the cursor overlay
// Assumes: Bound into every hcov_top instance
// Notes: Single clock domain, reset disables every check
`timescale 1ns/10ps
`default_nettype none
module hcov_props #(
   parameter COORD_W = 11,
   parameter LINE_W = 12
) (
   input wire CLK,
   input wire RST,
   input wire IO_WR,
   input wire IO_RD,
   input wire MONO_ADDR,
   input wire ENHANCED_MODE,
   input wire TRUE_COLOR,
   input wire FOUR_PLANE,
   input wire MEM_HALF_MB,
   input wire FRAME_START,
   input wire CURSOR_HIT,
   input wire MEM_REQ,
   input wire MEM_ACK,
   input wire [15:0] IO_ADDR,
   input wire [15:0] MEM_RDATA,
   input wire [7:0] IO_WDATA,
   input wire [7:0] IO_RDATA,
   input wire [COORD_W-1:0] PIX_X,
   input wire [COORD_W-1:0] PIX_Y,
   input wire [COORD_W-1:0] ACTIVE_W,
   input wire [COORD_W-1:0] ACTIVE_H,
   input wire [23:0] SCREEN_PIXEL,
   input wire [23:0] PIX_OUT,
   input wire [LINE_W-1:0] MEM_LINE,
   input wire [10:0] MEM_WORD
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);
   wire hp = FOUR_PLANE && MEM_HALF_MB;
   wire take = MEM_REQ && MEM_ACK;
   wire on_scr = (PIX_X < ACTIVE_W) && (PIX_Y < ACTIVE_H);
   reg [9:0] n_q;
   // Words taken in the current fetch
   always @(posedge CLK or posedge RST) begin
      if (RST) begin
         n_q <= 10'h000;
      end else begin
         n_q <= MEM_REQ ? n_q + {9'h000, MEM_ACK} : 10'h000;
      end
   end
   a_off_legacy: assert property (!$past(ENHANCED_MODE) |-> !CURSOR_HIT)
      else $error("cursor shown outside enhanced mode");
   a_miss_passes: assert property (!CURSOR_HIT |-> PIX_OUT == $past(SCREEN_PIXEL))
      else $error("screen pixel not passed through");
   a_hit_on_screen: assert property (CURSOR_HIT |-> $past(on_scr))
      else $error("cursor shown off the active display");
   a_fetch_start: assert property ($rose(MEM_REQ) |-> $past(FRAME_START)
      && $past(ENHANCED_MODE) && MEM_WORD == 11'h000) else $error("bad fetch start");
   a_addr_holds: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ
      && $stable(MEM_WORD) && $stable(MEM_LINE)) else $error("address moved before ack");
   a_word_step: assert property (take && MEM_WORD != (hp ? 11'h0FF : 11'h1FF)
      |=> MEM_WORD == $past(MEM_WORD) + 11'h001) else $error("word address not stepped");
   a_half_wrap: assert property (take && hp && MEM_WORD == 11'h0FF |=> !MEM_REQ
      || (MEM_WORD == 11'h000 && MEM_LINE == $past(MEM_LINE) + 1'b1))
      else $error("second image line not taken");
   a_word_count: assert property ($fell(MEM_REQ) |-> n_q == 10'h200)
      else $error("fetch length not 512 words");
   a_rdata_hold: assert property (!IO_RD |=> $stable(IO_RDATA))
      else $error("read data changed without a read");
   a_unmapped: assert property ((IO_WR && IO_ADDR == 16'h03D4 && IO_WDATA == 8'h60) ##2
      (IO_RD && IO_ADDR == 16'h03D5 && !MONO_ADDR) |=> IO_RDATA == 8'h00)
      else $error("unmapped index not read as zero");
   c_fetch_done: cover property ($fell(MEM_REQ));
   c_half_fetch: cover property (take && hp && MEM_WORD == 11'h0FF);
   c_hit_run: cover property (CURSOR_HIT ##1 !CURSOR_HIT);
endmodule // hcov_props
bind hcov_top hcov_props #(.COORD_W(COORD_W), .LINE_W(LINE_W)) i_hcov_props (
   .CLK(CLK), .RST(RST), .IO_WR(IO_WR), .IO_RD(IO_RD), .MONO_ADDR(MONO_ADDR),
   .ENHANCED_MODE(ENHANCED_MODE), .TRUE_COLOR(TRUE_COLOR), .FOUR_PLANE(FOUR_PLANE),
   .MEM_HALF_MB(MEM_HALF_MB), .FRAME_START(FRAME_START), .CURSOR_HIT(CURSOR_HIT),
   .MEM_REQ(MEM_REQ), .MEM_ACK(MEM_ACK), .IO_ADDR(IO_ADDR), .MEM_RDATA(MEM_RDATA),
   .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .PIX_X(PIX_X), .PIX_Y(PIX_Y),
   .ACTIVE_W(ACTIVE_W), .ACTIVE_H(ACTIVE_H), .SCREEN_PIXEL(SCREEN_PIXEL),
   .PIX_OUT(PIX_OUT), .MEM_LINE(MEM_LINE), .MEM_WORD(MEM_WORD));
`default_nettype wire

// File: tb/hcov_top_tb_top.sv
// Purpose: Self-checking bench of the cursor overlay
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Register, fetch and pixel results compared with a model
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin n_errors++; \
   $display("Error %s exp %h got %h", n, e, s); end end
module hcov_top_tb_top;
   logic CLK = 0, RST = 1, IO_WR = 0, IO_RD = 0, MONO_ADDR = 0, ENHANCED_MODE = 1;
   logic TRUE_COLOR = 0, FOUR_PLANE = 0, MEM_HALF_MB = 0, FRAME_START = 0, MEM_ACK = 0;
   logic CURSOR_HIT, MEM_REQ;
   logic [15:0] IO_ADDR = '0, MEM_RDATA = '0;
   logic [7:0] IO_WDATA = '0, IO_RDATA;
   logic [10:0] PIX_X = '0, PIX_Y = '0, ACTIVE_W = 11'h12C, ACTIVE_H = 11'h0C8, MEM_WORD;
   logic [23:0] SCREEN_PIXEL = '0, PIX_OUT;
   logic [11:0] MEM_LINE, yl;
   logic [15:0] img [512];
   logic [24:0] e;
   int n_errors = 0, checks = 0, r [256], st [2][3], sp [2], ps [4];
   int q [$] = '{8'h4A, 8'h4B, 8'h45, 8'h4A, 8'h4B, 8'h4D};
   wire [15:0] pi = MONO_ADDR ? 16'h03B4 : 16'h03D4;
   always #25 CLK = ~CLK;
   hcov_top i_hcov_top (.CLK(CLK), .RST(RST), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
      .IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .MONO_ADDR(MONO_ADDR),
      .ENHANCED_MODE(ENHANCED_MODE), .TRUE_COLOR(TRUE_COLOR), .FOUR_PLANE(FOUR_PLANE),
      .MEM_HALF_MB(MEM_HALF_MB), .FRAME_START(FRAME_START), .PIX_X(PIX_X), .PIX_Y(PIX_Y),
      .ACTIVE_W(ACTIVE_W), .ACTIVE_H(ACTIVE_H), .SCREEN_PIXEL(SCREEN_PIXEL),
      .PIX_OUT(PIX_OUT), .CURSOR_HIT(CURSOR_HIT), .MEM_REQ(MEM_REQ), .MEM_LINE(MEM_LINE),
      .MEM_WORD(MEM_WORD), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
   // Video memory, random stalls, inverted data while not acking
   always @(posedge CLK) begin
      #1;
      yl = 12'(r[8'h4C] * 256 + r[8'h4D]);
      MEM_ACK = MEM_REQ & ($urandom % 3 != 0);
      MEM_RDATA = img[FOUR_PLANE && MEM_HALF_MB ? 9'((MEM_LINE - yl) * 256 + MEM_WORD[7:0])
         : MEM_WORD[8:0]] ^ {16{!MEM_ACK}};
      if (MEM_ACK && !(FOUR_PLANE && MEM_HALF_MB)) `CHK("line", yl, MEM_LINE)
   end
   task automatic conclude();
      $display("Checks %0d, errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic io(input logic [15:0] a, input logic [7:0] v, input logic w);
      @(posedge CLK);
      #1;
      IO_ADDR = a;
      IO_WDATA = v;
      IO_WR = w;
      IO_RD = !w;
      @(posedge CLK);
      #1;
      IO_WR = 0;
      IO_RD = 0;
   endtask
   task automatic wr(input int i, input int v);
      v &= 255;
      io(pi, 8'(i), 1);
      io(pi | 16'h0001, 8'(v), 1);
      if (i inside {[8'h45:8'h4F]} && r[8'h39] != 8'hA0) return;
      case (i)
         8'h45: r[i] = v & 15;
         8'h48: begin
            r[i] = v & 7;
            ps = '{r[8'h47] + 256 * r[8'h46], r[8'h49] + 256 * r[i], r[8'h4E], r[8'h4F]};
         end
         8'h4A, 8'h4B: begin
            st[i % 2][sp[i % 2]] = v;
            sp[i % 2] = (sp[i % 2] + 1) % 3;
         end
         default: if (i inside {8'h0E, 8'h0F, 8'h39, [8'h46:8'h4F]})
            r[i] = v & (i == 8'h46 ? 7 : i > 8'h4D ? 63 : 255);
      endcase
   endtask
   task automatic rc(input int i);
      int x;
      x = (i inside {8'h4A, 8'h4B}) ? st[i % 2][sp[i % 2]] : r[i];
      if (i == 8'h45) sp = '{0, 0};
      io(pi, 8'(i), 1);
      io(pi | 16'h0001, 8'h00, 0);
      `CHK("register", 8'(x), IO_RDATA)
   endtask
   task automatic fetch();
      // Bottom eight rows padded with AND ones and XOR zeros
      foreach (img[k]) img[k] = k < 448 ? 16'($urandom) : k % 2 ? 16'h0000 : 16'hFFFF;
      @(posedge CLK);
      #1;
      FRAME_START = 1;
      @(posedge CLK);
      #1;
      FRAME_START = 0;
      `CHK("fetch", 1'b1, MEM_REQ)
      for (int k = 0; k < 3000 && MEM_REQ !== 1'b0; k++) #50;
      if (MEM_REQ !== 1'b0) begin
         n_errors++;
         conclude();
      end
   endtask
   function automatic logic [24:0] px(input int x, input int y, input logic [23:0] s);
      int z, c, w;
      logic a, b;
      logic [23:0] f, g;
      z = r[8'h45][3] ? 3 : r[8'h45][2] ? 2 : 1;
      c = ps[2] + (x - ps[0]) / z;
      w = ps[3] + (y - ps[1]) / z;
      if (!(ENHANCED_MODE && r[8'h45][0] && x >= ps[0] && y >= ps[1] && c < 64 && w < 64
         && x < ACTIVE_W && y < ACTIVE_H)) return {1'b0, s};
      a = img[w * 8 + c / 16 * 2][15 - c % 16];
      b = img[w * 8 + c / 16 * 2 + 1][15 - c % 16];
      f = (TRUE_COLOR || z > 1) ? 24'(st[0][2] * 65536 + st[0][1] * 256 + st[0][0]) : 24'(r[14]);
      g = (TRUE_COLOR || z > 1) ? 24'(st[1][2] * 65536 + st[1][1] * 256 + st[1][0]) : 24'(r[15]);
      if (r[8'h45][1]) return {1'b1, !a ? s : b ? f : g};
      return {1'b1, !a ? (b ? f : g) : (b ? ~s : s)};
   endfunction
   task automatic sweep();
      for (int k = 0; k < 300; k++) begin
         @(posedge CLK);
         #1;
         if (k > 0) `CHK("pixel", e, {CURSOR_HIT, PIX_OUT})
         PIX_X = 11'(ps[0] - 4 + $urandom % 200);
         PIX_Y = 11'(ps[1] - 4 + $urandom % 200);
         SCREEN_PIXEL = 24'($urandom);
         e = px(PIX_X, PIX_Y, SCREEN_PIXEL);
      end
   endtask
   initial begin
      void'($urandom(55254));
      repeat (4) @(posedge CLK);
      #1;
      RST = 0;
      for (int i = 0; i < 256; i++) rc(i);
      wr(8'h45, 1);
      rc(8'h45);
      for (int i = 14; i < 16; i++) wr(i, $urandom);
      for (int i = 14; i < 16; i++) rc(i);
      wr(8'h39, 8'hA0);
      wr(8'h4C, $urandom % 16);
      wr(8'h4D, $urandom);
      rc(8'h45);
      repeat (4) wr(8'h4A, $urandom);
      repeat (5) wr(8'h4B, $urandom);
      foreach (q[k]) rc(q[k]);
      MONO_ADDR = 1;
      io(16'h03D4, 8'h0E, 1);
      io(16'h03D5, 8'h5A, 1);
      rc(8'h0E);
      wr(8'h0F, 8'h3C);
      MONO_ADDR = 0;
      rc(8'h0F);
      for (int p = 0; p < 12; p++) begin
         wr(8'h45, 1 + 2 * p[0] + 4 * (p % 3));
         {TRUE_COLOR, MEM_HALF_MB, FOUR_PLANE} = 3'(p >> 1);
         fetch();
         wr(8'h47, $urandom);
         wr(8'h46, p / 11);
         wr(8'h49, p == 5 ? 200 : $urandom % 210);
         wr(8'h4E, $urandom % 64);
         wr(8'h4F, $urandom % 64);
         sweep();
         wr(8'h48, 0);
         sweep();
      end
      ENHANCED_MODE = 0;
      sweep();
      ENHANCED_MODE = 1;
      wr(8'h45, 8'h02);
      sweep();
      wr(8'h39, 8'h00);
      wr(8'h45, 8'h01);
      rc(8'h45);
      for (int i = 8'h46; i < 8'h50; i++) rc(i);
      io(pi, 8'h00, 0);
      `CHK("index", 8'h4F, IO_RDATA)
      conclude();
   end
endmodule // hcov_top_tb_top
`default_nettype wire
